// >>> verilog/swp_pkg.sv
// Constants shared by the status and write-protect logic.
package swp_pkg;
   // Status word bit positions.
   localparam int BIT_BUSY = 0;
   localparam int BIT_LATCH = 1;
   localparam int BIT_GUARD_LO = 2;
   localparam int BIT_GUARD_HI = 6;
   localparam int BIT_MODE_LO = 7;
   localparam int BIT_MODE_HI = 8;
   localparam int BIT_QUAD = 9;
   localparam int BIT_PROG_PAUSED = 10;
   localparam int BIT_LOCK_LO = 11;
   localparam int BIT_LOCK_HI = 13;
   localparam int BIT_INVERT = 14;
   localparam int BIT_ERASE_PAUSED = 15;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   // Command codes seen on the serial link.
   localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] CMD_WRITE_LOCK = 8'h04;
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
   localparam logic [7:0] CMD_QUAD_PAGE_WRITE = 8'h32;
   localparam logic [7:0] CMD_SMALL_CLEAR = 8'h20;
   localparam logic [7:0] CMD_BLOCK32_CLEAR = 8'h52;
   localparam logic [7:0] CMD_BLOCK64_CLEAR = 8'hD8;
   localparam logic [7:0] CMD_ARRAY_CLEAR_A = 8'hC7;
   localparam logic [7:0] CMD_ARRAY_CLEAR_B = 8'h60;
   localparam logic [7:0] CMD_PAUSE = 8'h75;
   localparam logic [7:0] CMD_RESUME = 8'h7A;
   localparam logic [7:0] CMD_SEC_CLEAR = 8'h44;
   localparam logic [7:0] CMD_SEC_WRITE = 8'h42;
   // Lock modes.
   localparam logic [1:0] MODE_SOFT = 2'h0;
   localparam logic [1:0] MODE_HARD = 2'h1;
   localparam logic [1:0] MODE_POWER = 2'h2;
   localparam logic [1:0] MODE_OTP = 2'h3;
   // Array geometry.
   localparam logic [24:0] ARRAY_BYTES = 25'h1000000;
   localparam logic [24:0] WIDE_UNIT = 25'h0010000;
   localparam logic [24:0] FINE_UNIT = 25'h0000800;
   localparam logic [24:0] FINE_MAX = 25'h0008000;
   // Operation times.
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_PROG_US = 700;
   localparam int T_ERASE_US = 50000;
   localparam int T_STATUS_US = 5000;
   localparam int T_SEC_US = 5000;
   localparam int PROG_CYC = T_PROG_US * 1000 / CLK_PERIOD_NS;
   localparam int ERASE_CYC = T_ERASE_US * 1000 / CLK_PERIOD_NS;
   localparam int STATUS_CYC = T_STATUS_US * 1000 / CLK_PERIOD_NS;
   localparam int SEC_CYC = T_SEC_US * 1000 / CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_PROG = 3'b001,
      OP_ERASE = 3'b010,
      OP_STATUS = 3'b011,
      OP_SEC = 3'b100
   } swp_op_t;
endpackage

// >>> verilog/swp_region_guard.sv
// Decodes whether an array address lies in the guarded region.
`timescale 1ns/1ns
module swp_region_guard
   import swp_pkg::*;
(
   input wire logic [4:0] guard_in,   // Block-guard bits.
   input wire logic invert_in,        // Guard-invert bit.
   input wire logic [23:0] addr_in,   // Target byte address.
   output logic prot_out              // Address is protected.
);
   logic [24:0] size;
   logic [24:0] a;
   logic plain;

   always_comb begin
      a = {1'b0, addr_in};
      size = '0;
      plain = 1'b0;
      if (guard_in[2:0] == 3'h7) begin
         plain = 1'b1;
      end else if (guard_in[2:0] == 3'h0) begin
         plain = 1'b0;
      end else begin
         if (guard_in[4] == 1'b0) begin
            size = WIDE_UNIT << (guard_in[2:0] + 3'h1);
         end else if (guard_in[2]) begin
            size = FINE_MAX;
         end else begin
            size = FINE_UNIT << guard_in[1:0];
         end
         if (guard_in[3]) begin
            plain = (a < size);
         end else begin
            plain = (a >= (ARRAY_BYTES - size));
         end
      end
      // Inversion simply takes the complement, so xx000 guards all, xx111 none.
      prot_out = plain ^ invert_in; // see RQ7 see RQ16
   end
endmodule

// >>> verilog/swp_status_guard.sv
// Status word, write latch, lock modes and program/erase gating.
`timescale 1ns/1ns
// Behaviour
// RQ1: Sixteen-bit status word with fixed fields.
// RQ2: Busy bit high during program, erase, status write.
// RQ3: Latch bit shown; clear latch refuses writes.
// RQ4: Guard bits block program and erase regions.
// RQ5: Guard bits change only outside hardware lock.
// RQ6: Whole erase only if guard/invert uniform.
// RQ7: Invert bit guards complement of normal region.
// RQ8: Mode 00 accepts status write with latch.
// RQ9: Mode 01, guard pin low, rejects writes.
// RQ10: Mode 01, guard pin high, accepts writes.
// RQ11: Mode 10 locks until power cycle.
// RQ12: Mode 11 refuses status writes forever.
// RQ13: Quad bit turns guard pins into data.
// RQ14: Host keeps quad off on tied pins.
// RQ15: Security lock bits only set, never cleared.
// RQ16: Invert bit stored and used in decode.
// RQ17: Pause sets erase or program paused flag.
// RQ18: Resume and power cycle clear paused flags.
// RQ19: Latch cleared by power-up and write commands.
// RQ20: Commands need chip select on byte boundary.
// RQ21: Low guard pin freezes guard and mode bits; code freezes them only in mode 01 with quad off.
// RQ22: Protected target leaves busy and array untouched.
module swp_status_guard
   import swp_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC,
   parameter int ERASE_CYCLES = ERASE_CYC,
   parameter int STATUS_CYCLES = STATUS_CYC,
   parameter int SEC_CYCLES = SEC_CYC
) (
   input wire logic clk_in,               // System clock, 100 MHz.
   input wire logic rstn_in,              // Synchronous reset, models power cycle.
   input wire logic [15:0] nv_image_in,   // Stored non-volatile status at power-up.
   input wire logic cmd_valid_in,         // One-cycle pulse: command framed.
   input wire logic [7:0] cmd_code_in,    // Command code.
   input wire logic [23:0] cmd_addr_in,   // Command address.
   input wire logic [15:0] cmd_data_in,   // Status write data.
   input wire logic cmd_aligned_in,       // Chip select rose on byte boundary.
   input wire logic guard_pin_in,         // Write-guard pin level, asynchronous.
   output logic [15:0] status_word_out,   // Live status word.
   output logic array_go_out,             // Pulse: array operation started.
   output logic [2:0] array_kind_out,     // Kind of started operation.
   output logic [23:0] array_addr_out,    // Address of started operation.
   output logic refused_out,              // Pulse: command refused.
   output logic quad_pins_on_out          // Guard and pause pins used as data.
);
   logic busy_r, busy_nxt, latch_r, latch_nxt, inv_r, inv_nxt, quad_r, quad_nxt;
   logic eps_r, eps_nxt, pps_r, pps_nxt, load_r, load_nxt;
   logic [4:0] guard_r, guard_nxt;
   logic [1:0] mode_r, mode_nxt;
   logic [2:0] lock_r, lock_nxt;
   logic [23:0] cnt_r, cnt_nxt;
   swp_op_t op_r, op_nxt;
   logic [15:0] stat_r, stat_nxt;
   logic go_r, go_nxt, ref_r, ref_nxt;
   logic [2:0] kind_r, kind_nxt;
   logic [23:0] gaddr_r, gaddr_nxt;
   logic wp1_r, wp2_r, wp3_r, wp_r, wp_nxt;
   logic prot, wp_eff, sr_ok, uni, accept;
   logic [1:0] sec_idx;

   function automatic logic is_region_cmd(input logic [7:0] c);
      is_region_cmd = (c == CMD_PAGE_WRITE) || (c == CMD_QUAD_PAGE_WRITE) ||
         (c == CMD_SMALL_CLEAR) || (c == CMD_BLOCK32_CLEAR) || (c == CMD_BLOCK64_CLEAR);
   endfunction

   function automatic logic is_whole_clear(input logic [7:0] c);
      is_whole_clear = (c == CMD_ARRAY_CLEAR_A) || (c == CMD_ARRAY_CLEAR_B);
   endfunction

   function automatic logic [23:0] dur(input swp_op_t k);
      case (k)
         OP_PROG: dur = 24'(PROG_CYCLES);
         OP_ERASE: dur = 24'(ERASE_CYCLES);
         OP_STATUS: dur = 24'(STATUS_CYCLES);
         default: dur = 24'(SEC_CYCLES);
      endcase
   endfunction

   swp_region_guard u_region (
      .guard_in(guard_r),
      .invert_in(inv_r),
      .addr_in(cmd_addr_in),
      .prot_out(prot)
   );

   // Pin synchroniser: a change counts once the second and third stages agree.
   always_comb begin
      wp_nxt = (wp2_r == wp3_r) ? wp3_r : wp_r;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         wp1_r <= 1'b1;
         wp2_r <= 1'b1;
         wp3_r <= 1'b1;
         wp_r <= 1'b1;
      end else begin
         wp1_r <= guard_pin_in;
         wp2_r <= wp1_r;
         wp3_r <= wp2_r;
         wp_r <= wp_nxt;
      end
   end

   // With quad on the guard pin carries data, so it no longer locks.
   assign wp_eff = quad_r | wp_r; // see RQ13
   assign uni = (guard_r[2:0] == 3'h0 && !inv_r) || (guard_r[2:0] == 3'h7 && inv_r); // see RQ6
   assign sec_idx = cmd_addr_in[13:12];
   always_comb begin
      sr_ok = 1'b0;
      case (mode_r)
         MODE_SOFT: sr_ok = 1'b1; // see RQ8
         MODE_HARD: sr_ok = wp_eff; // see RQ9 see RQ10 see RQ21 see RQ5
         MODE_POWER: sr_ok = 1'b0; // see RQ11
         default: sr_ok = 1'b0; // see RQ12
      endcase
   end

   always_comb begin
      busy_nxt = busy_r;
      latch_nxt = latch_r;
      guard_nxt = guard_r;
      mode_nxt = mode_r;
      quad_nxt = quad_r;
      lock_nxt = lock_r;
      inv_nxt = inv_r;
      eps_nxt = eps_r;
      pps_nxt = pps_r;
      op_nxt = op_r;
      cnt_nxt = cnt_r;
      go_nxt = 1'b0;
      ref_nxt = 1'b0;
      kind_nxt = kind_r;
      gaddr_nxt = gaddr_r;
      load_nxt = 1'b0;
      accept = 1'b0;
      if (load_r) begin
         guard_nxt = nv_image_in[BIT_GUARD_HI:BIT_GUARD_LO];
         // A power cycle drops the power-supply lock back to software mode.
         mode_nxt = (nv_image_in[BIT_MODE_HI:BIT_MODE_LO] == MODE_POWER) ? MODE_SOFT :
            nv_image_in[BIT_MODE_HI:BIT_MODE_LO]; // see RQ11
         quad_nxt = nv_image_in[BIT_QUAD];
         lock_nxt = nv_image_in[BIT_LOCK_HI:BIT_LOCK_LO];
         inv_nxt = nv_image_in[BIT_INVERT];
      end else if (busy_r) begin
         if (cmd_valid_in && cmd_code_in == CMD_PAUSE && cmd_aligned_in &&
             (op_r == OP_PROG || op_r == OP_ERASE)) begin
            eps_nxt = (op_r == OP_ERASE); // see RQ17
            pps_nxt = (op_r == OP_PROG); // see RQ17
            busy_nxt = 1'b0;
         end else if (cnt_r <= 24'h000001) begin
            busy_nxt = 1'b0; // see RQ2
            op_nxt = OP_NONE;
            cnt_nxt = '0;
         end else begin
            cnt_nxt = cnt_r - 24'h000001;
         end
         if (cmd_valid_in && cmd_code_in != CMD_PAUSE) begin
            ref_nxt = 1'b1;
         end
      end else if (cmd_valid_in) begin
         if (!cmd_aligned_in) begin
            ref_nxt = 1'b1; // see RQ20
         end else if (cmd_code_in == CMD_WRITE_UNLOCK) begin
            latch_nxt = 1'b1;
         end else if (cmd_code_in == CMD_WRITE_LOCK) begin
            latch_nxt = 1'b0; // see RQ19
         end else if (cmd_code_in == CMD_RESUME) begin
            if (eps_r || pps_r) begin
               busy_nxt = 1'b1;
            end
            eps_nxt = 1'b0; // see RQ18
            pps_nxt = 1'b0;
         end else if (!latch_r || eps_r || pps_r) begin
            ref_nxt = 1'b1; // see RQ3
         end else if (cmd_code_in == CMD_STATUS_WRITE) begin
            if (sr_ok) begin
               accept = 1'b1;
               op_nxt = OP_STATUS;
               guard_nxt = cmd_data_in[BIT_GUARD_HI:BIT_GUARD_LO]; // see RQ4
               mode_nxt = cmd_data_in[BIT_MODE_HI:BIT_MODE_LO];
               quad_nxt = cmd_data_in[BIT_QUAD]; // see RQ13
               lock_nxt = lock_r | cmd_data_in[BIT_LOCK_HI:BIT_LOCK_LO]; // see RQ15
               inv_nxt = cmd_data_in[BIT_INVERT]; // see RQ16
            end else begin
               ref_nxt = 1'b1;
            end
         end else if (is_region_cmd(cmd_code_in)) begin
            if (prot) begin
               ref_nxt = 1'b1; // see RQ4 see RQ22
            end else begin
               accept = 1'b1;
               op_nxt = (cmd_code_in == CMD_PAGE_WRITE || cmd_code_in == CMD_QUAD_PAGE_WRITE) ?
                  OP_PROG : OP_ERASE;
            end
         end else if (is_whole_clear(cmd_code_in)) begin
            if (uni) begin
               accept = 1'b1;
               op_nxt = OP_ERASE;
            end else begin
               ref_nxt = 1'b1; // see RQ6
            end
         end else if (cmd_code_in == CMD_SEC_CLEAR || cmd_code_in == CMD_SEC_WRITE) begin
            if (sec_idx == 2'h0 || lock_r[sec_idx - 2'h1]) begin
               ref_nxt = 1'b1; // see RQ15
            end else begin
               accept = 1'b1;
               op_nxt = OP_SEC;
            end
         end
         if (accept) begin
            busy_nxt = 1'b1; // see RQ2
            latch_nxt = 1'b0; // see RQ19
            cnt_nxt = dur(op_nxt);
            go_nxt = (op_nxt != OP_STATUS);
            kind_nxt = op_nxt;
            gaddr_nxt = cmd_addr_in;
         end
      end
      stat_nxt = {eps_nxt, inv_nxt, lock_nxt, pps_nxt, quad_nxt, mode_nxt, guard_nxt,
         latch_nxt, busy_nxt}; // see RQ1
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         busy_r <= 1'b0;
         latch_r <= 1'b0; // see RQ19
         guard_r <= '0;
         mode_r <= MODE_SOFT;
         quad_r <= 1'b0;
         lock_r <= '0;
         inv_r <= 1'b0;
         eps_r <= 1'b0; // see RQ18
         pps_r <= 1'b0;
         op_r <= OP_NONE;
         cnt_r <= '0;
         stat_r <= STATUS_RESET;
         go_r <= 1'b0;
         ref_r <= 1'b0;
         kind_r <= OP_NONE;
         gaddr_r <= '0;
         load_r <= 1'b1;
      end else begin
         busy_r <= busy_nxt;
         latch_r <= latch_nxt;
         guard_r <= guard_nxt;
         mode_r <= mode_nxt;
         quad_r <= quad_nxt;
         lock_r <= lock_nxt;
         inv_r <= inv_nxt;
         eps_r <= eps_nxt;
         pps_r <= pps_nxt;
         op_r <= op_nxt;
         cnt_r <= cnt_nxt;
         stat_r <= stat_nxt;
         go_r <= go_nxt;
         ref_r <= ref_nxt;
         kind_r <= kind_nxt;
         gaddr_r <= gaddr_nxt;
         load_r <= load_nxt;
      end
   end

   assign status_word_out = stat_r;
   assign array_go_out = go_r;
   assign array_kind_out = kind_r;
   assign array_addr_out = gaddr_r;
   assign refused_out = ref_r;
   assign quad_pins_on_out = quad_r;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_unlock;
      cmd_valid_in && cmd_aligned_in && cmd_code_in == CMD_WRITE_UNLOCK && !busy_r && !load_r;
   endsequence
   sequence s_latch_shown;
      latch_r ##0 status_word_out[BIT_LATCH];
   endsequence

   a_latch_sets_shown: assert property (s_unlock |=> s_latch_shown) // see RQ3
      else $error("write unlock did not set latch");
   a_no_latch_refuse: assert property (cmd_valid_in && !latch_r && !busy_r && !load_r &&
      cmd_code_in == CMD_STATUS_WRITE |=> !busy_r && refused_out) // see RQ3
      else $error("status write accepted without latch");
   a_busy_shown: assert property (busy_r == status_word_out[BIT_BUSY]) // see RQ2
      else $error("busy bit disagrees with state");
   a_prot_target_kept: assert property (cmd_valid_in && !busy_r && !load_r && prot &&
      is_region_cmd(cmd_code_in) |=> !busy_r && !array_go_out) // see RQ22
      else $error("protected target started");
   a_mode_two_locks: assert property (mode_r == MODE_POWER && !load_r |=>
      mode_r == MODE_POWER) // see RQ11
      else $error("power lock mode left without power cycle");
   a_otp_locks_hold: assert property (!load_r |=> // see RQ15
      (lock_r & $past(lock_r)) == $past(lock_r))
      else $error("security lock bit cleared");
   a_hw_freeze: assert property (mode_r == MODE_HARD && !wp_eff && !load_r |=>
      $stable(guard_r) && $stable(mode_r)) // see RQ21
      else $error("guard bits changed under hardware lock");
   a_whole_clear_gate: assert property (cmd_valid_in && cmd_aligned_in && latch_r &&
      !busy_r && !load_r && !eps_r && !pps_r && is_whole_clear(cmd_code_in) && !uni
      |=> !busy_r && refused_out) // see RQ6
      else $error("whole erase ran with mixed guard bits");
   a_pause_flag: assert property (busy_r && op_r == OP_ERASE && cmd_valid_in && // see RQ17
      cmd_aligned_in && cmd_code_in == CMD_PAUSE |=> status_word_out[BIT_ERASE_PAUSED])
      else $error("erase pause flag not shown");
   a_unaligned_refused: assert property (cmd_valid_in && !cmd_aligned_in && !busy_r &&
      !load_r |=> refused_out && $stable(latch_r)) // see RQ20
      else $error("unaligned command executed");
endmodule

// >>> test/swp_host_model.sv
// Host-side model that frames flash commands towards the status logic.
`timescale 1ns/1ns
module swp_host_model (
   input wire logic clk_in,          // System clock.
   output logic cmd_valid_out,       // One-cycle framed-command pulse.
   output logic [7:0] cmd_code_out,  // Command code.
   output logic [23:0] cmd_addr_out, // Command address.
   output logic [15:0] cmd_data_out, // Status write data.
   output logic cmd_aligned_out,     // Chip select rose on a byte boundary.
   output logic guard_pin_out        // Write-guard pin level.
);
   initial begin
      cmd_valid_out = 1'b0;
      cmd_code_out = 8'h00;
      cmd_addr_out = 24'h000000;
      cmd_data_out = 16'h0000;
      cmd_aligned_out = 1'b0;
      guard_pin_out = 1'b1;
   end
   // Lines outside a command show the inverse of their last value, so stale data never matches.
   task automatic send(input logic [7:0] code, input logic [23:0] addr,
                       input logic [15:0] data, input logic aligned);
      @(negedge clk_in);
      cmd_valid_out = 1'b1;
      cmd_code_out = code;
      cmd_addr_out = addr;
      cmd_data_out = data;
      cmd_aligned_out = aligned;
      @(negedge clk_in);
      cmd_valid_out = 1'b0;
      cmd_code_out = ~code;
      cmd_addr_out = ~addr;
      cmd_data_out = ~data;
      cmd_aligned_out = ~aligned;
   endtask
   // The pin is always driven by this model and never tied, so quad mode is safe.
   task automatic set_pin(input logic level);
      @(negedge clk_in);
      guard_pin_out = level;
   endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the status word and write-protect logic.
`timescale 1ns/1ns
module testbench;
   import swp_pkg::*;
   typedef struct packed {logic go; logic [2:0] kind; logic [23:0] addr;} swp_note_t;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [15:0] nv_image_in = 16'h0000;
   logic cmd_valid, cmd_aligned, guard_pin, array_go_out, refused_out, quad_pins_on_out;
   logic [7:0] cmd_code;
   logic [23:0] cmd_addr, array_addr_out, a;
   logic [15:0] cmd_data, status_word_out, img_exp;
   logic [2:0] array_kind_out;
   logic [7:0] codes [4] = '{CMD_QUAD_PAGE_WRITE, CMD_SMALL_CLEAR, CMD_BLOCK32_CLEAR,
      CMD_BLOCK64_CLEAR};
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   swp_note_t notes_q [$];
   swp_note_t nt;
   always #5 clk_in = ~clk_in;
   swp_host_model host (.clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
      .cmd_addr_out(cmd_addr), .cmd_data_out(cmd_data), .cmd_aligned_out(cmd_aligned),
      .guard_pin_out(guard_pin));
   // Short busy counts keep the run small; checks that follow an operation wait for busy to drop, not for a fixed count.
   swp_status_guard #(.PROG_CYCLES(8), .ERASE_CYCLES(12), .STATUS_CYCLES(6), .SEC_CYCLES(6)) DUT (
      .clk_in(clk_in), .rstn_in(rstn_in), .nv_image_in(nv_image_in), .cmd_valid_in(cmd_valid),
      .cmd_code_in(cmd_code), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
      .cmd_aligned_in(cmd_aligned), .guard_pin_in(guard_pin), .status_word_out(status_word_out),
      .array_go_out(array_go_out), .array_kind_out(array_kind_out),
      .array_addr_out(array_addr_out), .refused_out(refused_out),
      .quad_pins_on_out(quad_pins_on_out));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // res: 0 no pulse expected, 1 refusal, 2 start of the given kind.
   task automatic cmd(input logic [7:0] code, input logic [23:0] addr, input logic [15:0] data,
                      input int res, input logic [2:0] kind, input logic al);
      if (res != 0) notes_q.push_back('{res == 2, kind, addr});
      host.send(code, addr, data, al);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 200 && status_word_out[BIT_BUSY] !== 1'b0; i++) @(negedge clk_in);
   endtask
   task automatic sw(input logic [15:0] d, input logic ok);
      cmd(CMD_WRITE_UNLOCK, 24'h0, 16'h0, 0, 3'h0, 1'b1);
      cmd(CMD_STATUS_WRITE, 24'h0, d, ok ? 0 : 1, 3'h0, 1'b1);
      if (ok) begin
         check(status_word_out[BIT_BUSY], 1'b1, "busy after status write");
         wait_idle();
      end
   endtask
   task automatic power_cycle(input logic [15:0] img);
      rstn_in = 1'b0;
      nv_image_in = img;
      repeat (20) @(negedge clk_in);
      check(status_word_out, 16'h0000, "word in reset");
      rstn_in = 1'b1;
      repeat (3) @(negedge clk_in);
   endtask
   always @(negedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   always @(negedge clk_in) begin
      if (array_go_out === 1'b1 || refused_out === 1'b1) begin
         if (notes_q.size() == 0) begin
            check(1, 0, "unexpected result pulse");
         end else begin
            nt = notes_q.pop_front();
            check(array_go_out, nt.go, "start versus refusal");
            if (nt.go) check({array_kind_out, array_addr_out}, {nt.kind, nt.addr},
               "op");
         end
      end
   end
   initial begin
      void'($urandom(32'h01851AE3));
      power_cycle(16'h0000);
      check(status_word_out, 16'h0000, "word after power-up");
      cmd(CMD_PAGE_WRITE, 24'h000100, 16'h0, 1, 3'h0, 1'b1);
      cmd(CMD_STATUS_WRITE, 24'h0, 16'h0080, 1, 3'h0, 1'b1);
      cmd(CMD_WRITE_UNLOCK, 24'h0, 16'h0, 1, 3'h0, 1'b0);
      cmd(CMD_WRITE_UNLOCK, 24'h0, 16'h0, 0, 3'h0, 1'b1);
      check(status_word_out, 16'h0002, "latch shown");
      cmd(CMD_WRITE_LOCK, 24'h0, 16'h0, 0, 3'h0, 1'b1);
      check(status_word_out, 16'h0000, "latch dropped");
      sw(16'h4004, 1'b1);
      check(status_word_out, 16'h4004, "invert and guard stored");
      for (int i = 0; i < 8; i++) begin
         a = (i % 2 == 1) ? 24'hFC0000 | 24'($urandom() & 32'h3FFFF) :
            24'($urandom() % 32'hFC0000);
         if (i < 2) a = i ? 24'hFC0000 : 24'hFBFFFF;
         cmd(CMD_WRITE_UNLOCK, 24'h0, 16'h0, 0, 3'h0, 1'b1);
         cmd(codes[i % 4], a, 16'h0, a < 24'hFC0000 ? 1 : 2,
            i % 4 ? OP_ERASE : OP_PROG, 1'b1);
         wait_idle();
      end
      // The latch is set first, so only the mixed guard bits can refuse the whole erase.
      cmd(CMD_WRITE_UNLOCK, 24'h0, 16'h0, 0, 3'h0, 1'b1);
      cmd(CMD_ARRAY_CLEAR_A, 24'h0, 16'h0, 1, 3'h0, 1'b1);
      sw(16'h0000, 1'b1);
      for (int j = 0; j < 2; j++) begin
         cmd(CMD_WRITE_UNLOCK, 24'h0, 16'h0, 0, 3'h0, 1'b1);
         cmd(j ? CMD_ARRAY_CLEAR_B : CMD_ARRAY_CLEAR_A, 24'h0, 16'h0, 2, OP_ERASE,
            1'b1);
         cmd(CMD_PAUSE, 24'h0, 16'h0, 0, 3'h0, 1'b1);
         check({status_word_out[BIT_ERASE_PAUSED], status_word_out[BIT_BUSY]},
            2'b10, "pause");
         cmd(CMD_RESUME, 24'h0, 16'h0, 0, 3'h0, 1'b1);
         check({status_word_out[BIT_ERASE_PAUSED], status_word_out[BIT_BUSY]},
            2'b01, "resume");
         wait_idle();
      end
      sw(16'h0080, 1'b1);
      host.set_pin(1'b0);
      repeat (5) @(negedge clk_in);
      sw(16'h0000, 1'b0);
      check(status_word_out[8:2], 7'h20, "frozen guard and mode");
      host.set_pin(1'b1);
      repeat (5) @(negedge clk_in);
      sw(16'h0000, 1'b1);
      sw(16'h0800, 1'b1);
      sw(16'h0000, 1'b1);
      check(status_word_out, 16'h0800, "lock bit sticks");
      cmd(CMD_WRITE_UNLOCK, 24'h0, 16'h0, 0, 3'h0, 1'b1);
      cmd(CMD_SEC_WRITE, 24'h001000, 16'h0, 1, 3'h0, 1'b1);
      cmd(CMD_SEC_CLEAR, 24'h000000, 16'h0, 1, 3'h0, 1'b1);
      cmd(CMD_SEC_WRITE, 24'h002000, 16'h0, 2, OP_SEC, 1'b1);
      wait_idle();
      sw(16'h0900, 1'b1);
      sw(16'h0000, 1'b0);
      check(status_word_out, 16'h0902, "power lock holds");
      cmd(CMD_PAGE_WRITE, 24'h000010, 16'h0, 2, OP_PROG, 1'b1);
      cmd(CMD_PAUSE, 24'h0, 16'h0, 0, 3'h0, 1'b1);
      check(status_word_out[BIT_PROG_PAUSED], 1'b1, "program paused");
      // The stored image keeps the one-time lock bit that was set earlier.
      power_cycle(16'h0B00);
      check({quad_pins_on_out, status_word_out}, 17'h10A00, "after power cycle");
      sw(16'h0380, 1'b1);
      sw(16'h0200, 1'b0);
      check(status_word_out, 16'h0B82, "permanent lock");
      repeat (3) @(negedge clk_in);
      a = 24'($urandom());
      power_cycle(a[15:0]);
      img_exp = a[15:0] & 16'h7BFC;
      if (img_exp[BIT_MODE_HI:BIT_MODE_LO] == MODE_POWER) begin
         img_exp[BIT_MODE_HI:BIT_MODE_LO] = MODE_SOFT;
      end
      check(status_word_out, img_exp, "random image loaded");
      check(quad_pins_on_out, img_exp[BIT_QUAD], "quad pin mode");
      check(notes_q.size(), 0, "results still owed");
      end_sim();
   end
endmodule
